// File: inc/fsc_pkg.sv
// Shared constants for the front side bus sideband control block.
package fsc_pkg;

  // ==========================================================
  // Register map
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_VECTOR = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_MASK = 8'h0c;
  localparam logic [7:0] REG_STATE = 8'h10;

  // ==========================================================
  // Control register fields
  localparam int CTRL_NE_BIT = 0;
  localparam int CTRL_LIC_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h2;
  localparam logic [31:0] VECTOR_RESET = 32'h0000_0000;

  // ==========================================================
  // Status and mask fields
  localparam int STAT_W = 6;
  localparam int ST_INTERNAL_ERROR_OUT = 0;
  localparam int ST_DEFER = 1;
  localparam int ST_INIT = 2;
  localparam int ST_BIST = 3;
  localparam int ST_NMI = 4;
  localparam int ST_PRIO = 5;
  localparam logic [5:0] STAT_RESET = 6'h00;

  // ==========================================================
  // State register fields
  localparam int SV_INTERNAL_ERROR_OUT = 0;
  localparam int SV_LOCK = 1;
  localparam int SV_INIT = 2;
  localparam int SV_IGN = 3;
  localparam int SV_LINT0 = 4;
  localparam int SV_LINT1 = 5;
  localparam int SV_FPERR = 6;
  localparam int SV_ID_LO = 8;

  // ==========================================================
  // Pin synchroniser and startup timing
  localparam int SYNC_W = 4;
  localparam int SY_INIT = 0;
  localparam int SY_IGN = 1;
  localparam int SY_LINT0 = 2;
  localparam int SY_LINT1 = 3;
  localparam logic [3:0] SYNC_IDLE = 4'h3;
  localparam logic [1:0] BOOT_SAMPLE = 2'h2;

  typedef enum logic [1:0] {BOOT_SETTLE, BOOT_RUN} fsc_boot_e;
  typedef enum logic {LOCK_IDLE, LOCK_HELD} fsc_lock_e;

endpackage

// File: hw/fsc_sync.sv
// Two flip-flop synchroniser bank for asynchronous pin inputs.
module fsc_sync
  import fsc_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [SYNC_W-1:0] async_in,
  output logic [SYNC_W-1:0] sync_out
);

  logic [SYNC_W-1:0] stage1;

  // The first stage feeds only the second, so metastability never reaches logic.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      stage1 <= SYNC_IDLE;
      sync_out <= SYNC_IDLE;
    end else begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end

endmodule

// File: hw/fsc_lock_seq.sv
// Atomic sequence driver and priority request observer.
module fsc_lock_seq
  import fsc_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic begin_in,
  input wire logic end_in,
  input wire logic prio_req_in,
  output logic atomic_n_out,
  output logic atomic_oe_n_out,
  output logic active_out,
  output logic prio_hit_out
);

  fsc_lock_e state;
  fsc_lock_e next_state;

  always_comb begin
    next_state = state;
    case (state)
      LOCK_IDLE: begin
        if (begin_in) begin
          next_state = LOCK_HELD;
        end
      end
      LOCK_HELD: begin
        if (end_in) begin
          next_state = LOCK_IDLE;
        end
      end
      default: begin
        next_state = LOCK_IDLE;
      end
    endcase
  end

  wire next_held = (next_state == LOCK_HELD);

  // The pin is released rather than driven high so other agents may share it.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state <= LOCK_IDLE;
      atomic_n_out <= 1'b1;
      atomic_oe_n_out <= 1'b1;
      active_out <= 1'b0;
      prio_hit_out <= 1'b0;
    end else begin
      state <= next_state;
      atomic_n_out <= !next_held;
      atomic_oe_n_out <= !next_held;
      active_out <= next_held;
      prio_hit_out <= prio_req_in && next_held;
    end
  end

endmodule

// File: hw/fsc_top.sv
// Processor-side sideband control: deferred phase, errors, init, interrupts and lock.
//
// Our own choices: the address-and-strobe port and the register offsets.
module fsc_top
  import fsc_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic [ADDR_W-1:0] reg_addr_in,
  input wire logic [DATA_W-1:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [DATA_W-1:0] reg_rdata_out,
  output logic irq_out,
  input wire logic [7:0] transaction_id_n_in,
  input wire logic id_strobe_n_in,
  input wire logic out_of_order_data_n_in,
  output logic deferred_start_out,
  output logic [7:0] deferred_id_out,
  output logic deferred_ood_out,
  input wire logic ood_data_valid_in,
  output logic ood_data_accept_out,
  input wire logic error_detect_in,
  output logic internal_error_n_out,
  output logic shutdown_req_out,
  input wire logic ignore_numeric_error_n_in,
  input wire logic fp_error_in,
  input wire logic fp_instr_in,
  output logic fp_exception_out,
  input wire logic soft_init_n_in,
  output logic integer_reset_out,
  output logic resume_out,
  output logic [DATA_W-1:0] resume_vector_out,
  output logic bist_start_out,
  input wire logic snoop_req_in,
  output logic snoop_ack_out,
  input wire logic [1:0] local_interrupt_pins_in,
  output logic [1:0] local_interrupt_out,
  output logic maskable_interrupt_request_out,
  output logic nmi_out,
  input wire logic lock_begin_in,
  input wire logic lock_end_in,
  input wire logic priority_request_n_in,
  output logic atomic_sequence_n_out,
  output logic atomic_sequence_oe_n_out
);

  function automatic logic fsc_rise(input logic now_v, input logic was_v);
    fsc_rise = now_v && !was_v;
  endfunction

  // ==========================================================
  // Reset release
  logic rst_meta_n;
  logic rst_n;

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_meta_n <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_n <= rst_meta_n;
    end
  end

  // ==========================================================
  // Asynchronous pin inputs
  logic [SYNC_W-1:0] pins_sync;

  fsc_sync u_sync (
    .clk_in(sys_clk_in),
    .rst_n_in(rst_n),
    .async_in({local_interrupt_pins_in[1], local_interrupt_pins_in[0], ignore_numeric_error_n_in, soft_init_n_in}),
    .sync_out(pins_sync)
  );

  wire init_act = !pins_sync[SY_INIT];
  wire ign_act = !pins_sync[SY_IGN];
  wire lint0 = pins_sync[SY_LINT0];
  wire lint1 = pins_sync[SY_LINT1];

  // ==========================================================
  // Bus-synchronous pins, captured once
  logic [7:0] id_q;
  logic ids_q;
  logic ood_q;
  logic prio_q;

  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      id_q <= 8'h00;
      ids_q <= 1'b0;
      ood_q <= 1'b0;
      prio_q <= 1'b0;
    end else begin
      id_q <= ~transaction_id_n_in;
      ids_q <= !id_strobe_n_in;
      ood_q <= !out_of_order_data_n_in;
      prio_q <= !priority_request_n_in;
    end
  end

  // ==========================================================
  // Registers
  logic [1:0] ctrl;
  logic [DATA_W-1:0] vector;
  logic [STAT_W-1:0] status;
  logic [STAT_W-1:0] mask;
  logic [STAT_W-1:0] events;

  wire wr_ctrl = reg_wr_in && (reg_addr_in == REG_CTRL);
  wire wr_vector = reg_wr_in && (reg_addr_in == REG_VECTOR);
  wire wr_status = reg_wr_in && (reg_addr_in == REG_STATUS);
  wire wr_mask = reg_wr_in && (reg_addr_in == REG_MASK);
  wire ne_bit = ctrl[CTRL_NE_BIT];
  wire lic_en = ctrl[CTRL_LIC_BIT];
  wire [STAT_W-1:0] w1c = wr_status ? reg_wdata_in[STAT_W-1:0] : STAT_RESET;
  wire [STAT_W-1:0] next_status = (status & ~w1c) | events;

  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= CTRL_RESET;
      vector <= VECTOR_RESET;
      status <= STAT_RESET;
      mask <= STAT_RESET;
      irq_out <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ctrl <= reg_wdata_in[1:0];
      end
      if (wr_vector) begin
        vector <= reg_wdata_in;
      end
      if (wr_mask) begin
        mask <= reg_wdata_in[STAT_W-1:0];
      end
      // A new event beats a clear in the same cycle.
      status <= next_status;
      irq_out <= |(next_status & mask);
    end
  end

  // ==========================================================
  // Deferred phase
  logic in_defer;

  wire defer_begin = ids_q;

  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      deferred_start_out <= 1'b0;
      deferred_id_out <= 8'h00;
      deferred_ood_out <= 1'b0;
      in_defer <= 1'b0;
      ood_data_accept_out <= 1'b0;
    end else begin
      deferred_start_out <= defer_begin;
      if (defer_begin) begin
        deferred_id_out <= id_q;
        deferred_ood_out <= ood_q;
      end
      if (defer_begin) begin
        in_defer <= ood_q;
      end else if (ood_data_valid_in) begin
        in_defer <= 1'b0;
      end
      ood_data_accept_out <= in_defer && ood_data_valid_in;
    end
  end

  // ==========================================================
  // Internal error and numeric error
  logic internal_error_out;
  logic fp_pending;

  wire ign_effective = ign_act && !ne_bit;
  wire fp_trap = fp_instr_in && fp_pending && !ign_effective;

  // Only the bus reset clears the error latch; software has no way to drop it.
  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      internal_error_out <= 1'b0;
      internal_error_n_out <= 1'b1;
      shutdown_req_out <= 1'b0;
      fp_pending <= 1'b0;
      fp_exception_out <= 1'b0;
    end else begin
      if (error_detect_in) begin
        internal_error_out <= 1'b1;
      end
      internal_error_n_out <= !(internal_error_out || error_detect_in);
      shutdown_req_out <= error_detect_in && !internal_error_out;
      if (fp_error_in) begin
        fp_pending <= 1'b1;
      end else if (fp_trap) begin
        fp_pending <= 1'b0;
      end
      fp_exception_out <= fp_trap;
    end
  end

  // ==========================================================
  // Soft init, self-test at reset release, snoops
  fsc_boot_e boot;
  logic [1:0] boot_cnt;
  logic init_was;
  logic bist_seen;

  wire boot_sample = (boot == BOOT_SETTLE) && (boot_cnt == BOOT_SAMPLE);
  wire run = (boot == BOOT_RUN);

  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      boot <= BOOT_SETTLE;
      boot_cnt <= 2'h0;
      bist_seen <= 1'b0;
    end else begin
      case (boot)
        BOOT_SETTLE: begin
          boot_cnt <= boot_cnt + 2'h1;
          if (boot_sample) begin
            boot <= BOOT_RUN;
            bist_seen <= init_act;
          end
        end
        BOOT_RUN: begin
          boot <= BOOT_RUN;
        end
        default: begin
          boot <= BOOT_SETTLE;
        end
      endcase
    end
  end

  wire init_rise = run && fsc_rise(init_act, init_was);
  wire init_fall = run && fsc_rise(init_was, init_act);

  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      init_was <= 1'b0;
      integer_reset_out <= 1'b0;
      resume_out <= 1'b0;
      resume_vector_out <= VECTOR_RESET;
      bist_start_out <= 1'b0;
      snoop_ack_out <= 1'b0;
    end else begin
      init_was <= init_act;
      integer_reset_out <= run && init_act;
      resume_out <= init_fall;
      if (init_fall) begin
        resume_vector_out <= vector;
      end
      bist_start_out <= boot_sample && init_act;
      snoop_ack_out <= snoop_req_in;
    end
  end

  // ==========================================================
  // Local interrupt pins
  logic lint1_was;

  wire nmi_rise = !lic_en && fsc_rise(lint1, lint1_was);

  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      lint1_was <= 1'b0;
      local_interrupt_out <= 2'h0;
      maskable_interrupt_request_out <= 1'b0;
      nmi_out <= 1'b0;
    end else begin
      lint1_was <= lint1;
      local_interrupt_out <= lic_en ? {lint1, lint0} : 2'h0;
      maskable_interrupt_request_out <= !lic_en && lint0;
      nmi_out <= nmi_rise;
    end
  end

  // ==========================================================
  // Atomic sequence
  logic lock_active;
  logic prio_hit;

  fsc_lock_seq u_lock (
    .clk_in(sys_clk_in),
    .rst_n_in(rst_n),
    .begin_in(lock_begin_in),
    .end_in(lock_end_in),
    .prio_req_in(prio_q),
    .atomic_n_out(atomic_sequence_n_out),
    .atomic_oe_n_out(atomic_sequence_oe_n_out),
    .active_out(lock_active),
    .prio_hit_out(prio_hit)
  );

  // ==========================================================
  // Events and read-back
  always_comb begin
    events = STAT_RESET;
    events[ST_INTERNAL_ERROR_OUT] = error_detect_in && !internal_error_out;
    events[ST_DEFER] = defer_begin;
    events[ST_INIT] = init_rise;
    events[ST_BIST] = boot_sample && init_act;
    events[ST_NMI] = nmi_rise;
    events[ST_PRIO] = prio_hit;
  end

  logic [DATA_W-1:0] state_word;

  always_comb begin
    state_word = 32'h0000_0000;
    state_word[SV_INTERNAL_ERROR_OUT] = internal_error_out;
    state_word[SV_LOCK] = lock_active;
    state_word[SV_INIT] = init_act;
    state_word[SV_IGN] = ign_act;
    state_word[SV_LINT0] = lint0;
    state_word[SV_LINT1] = lint1;
    state_word[SV_FPERR] = fp_pending;
    state_word[SV_ID_LO +: 8] = deferred_id_out;
  end

  logic [DATA_W-1:0] rd_mux;

  always_comb begin
    case (reg_addr_in)
      REG_CTRL: rd_mux = {30'h0, ctrl};
      REG_VECTOR: rd_mux = vector;
      REG_STATUS: rd_mux = {26'h0, status};
      REG_MASK: rd_mux = {26'h0, mask};
      REG_STATE: rd_mux = state_word;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // Read data is shown only in the cycle after each read strobe and is zero otherwise, so a stale value is never mistaken for an answer.
  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_out <= 32'h0000_0000;
    end else begin
      reg_rdata_out <= reg_rd_in ? rd_mux : 32'h0000_0000;
    end
  end

endmodule

// File: bench/fsc_checker_assertions.sv
// Port-level assertions for the sideband control block.
module fsc_checker
  import fsc_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic [7:0] transaction_id_n_in,
  input wire logic id_strobe_n_in,
  input wire logic out_of_order_data_n_in,
  input wire logic deferred_start_out,
  input wire logic [7:0] deferred_id_out,
  input wire logic deferred_ood_out,
  input wire logic ood_data_valid_in,
  input wire logic ood_data_accept_out,
  input wire logic error_detect_in,
  input wire logic internal_error_n_out,
  input wire logic shutdown_req_out,
  input wire logic snoop_req_in,
  input wire logic snoop_ack_out,
  input wire logic lock_begin_in,
  input wire logic lock_end_in,
  input wire logic atomic_sequence_n_out,
  input wire logic atomic_sequence_oe_n_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // Checks
  // Only the pin reset is seen here, so stimulus stays idle for the two internal reset edges.
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!rst_n_in);
  defer_start_a: assert property (!id_strobe_n_in |-> ##2 deferred_start_out
    && deferred_id_out == ~$past(transaction_id_n_in, 2) && deferred_ood_out == !$past(out_of_order_data_n_in, 2))
    else $error("deferred start wrong");
  ood_accept_a: assert property (ood_data_accept_out |-> $past(ood_data_valid_in))
    else $error("accept without data");
  internal_error_out_set_a: assert property (error_detect_in |=> !internal_error_n_out)
    else $error("error not flagged");
  internal_error_out_hold_a: assert property (!internal_error_n_out |=> !internal_error_n_out)
    else $error("error flag dropped");
  shutdown_first_a: assert property (error_detect_in && internal_error_n_out |=> shutdown_req_out)
    else $error("no shutdown request");
  shutdown_once_a: assert property (shutdown_req_out |-> $fell(internal_error_n_out))
    else $error("extra shutdown request");
  snoop_ack_a: assert property (snoop_ack_out == $past(snoop_req_in))
    else $error("snoop not answered");
  lock_take_a: assert property (lock_begin_in && atomic_sequence_n_out |=>
    !atomic_sequence_n_out && !atomic_sequence_oe_n_out) else $error("lock not taken");
  lock_keep_a: assert property (!atomic_sequence_n_out && !lock_end_in |=> !atomic_sequence_n_out)
    else $error("lock dropped early");
  lock_drop_a: assert property (!atomic_sequence_n_out && lock_end_in && !lock_begin_in |=>
    atomic_sequence_n_out && atomic_sequence_oe_n_out) else $error("lock not released");
  defer_ood_c: cover property (deferred_start_out && deferred_ood_out);
  lock_c: cover property (!atomic_sequence_n_out ##1 atomic_sequence_n_out);
  internal_error_out_c: cover property ($fell(internal_error_n_out));
endmodule
bind fsc_top fsc_checker u_fsc_checker (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
  .transaction_id_n_in(transaction_id_n_in), .id_strobe_n_in(id_strobe_n_in),
  .out_of_order_data_n_in(out_of_order_data_n_in), .deferred_start_out(deferred_start_out),
  .deferred_id_out(deferred_id_out), .deferred_ood_out(deferred_ood_out), .ood_data_valid_in(ood_data_valid_in),
  .ood_data_accept_out(ood_data_accept_out), .error_detect_in(error_detect_in),
  .internal_error_n_out(internal_error_n_out), .shutdown_req_out(shutdown_req_out), .snoop_req_in(snoop_req_in),
  .snoop_ack_out(snoop_ack_out), .lock_begin_in(lock_begin_in), .lock_end_in(lock_end_in),
  .atomic_sequence_n_out(atomic_sequence_n_out), .atomic_sequence_oe_n_out(atomic_sequence_oe_n_out));

// File: bench/fsc_agent_model.sv
// Far-side agent model: deferring agent and priority bus agent.
module fsc_agent_model (
  input wire logic clk_in,
  input wire logic atomic_n_in,
  output logic [7:0] id_n_out,
  output logic ids_n_out,
  output logic ood_n_out,
  output logic prio_n_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // Agent behaviour
  initial begin
    id_n_out = 8'hff;
    ids_n_out = 1'h1;
    ood_n_out = 1'h1;
    prio_n_out = 1'h1;
  end
  // After the strobe the id lines invert, so a stale capture cannot pass.
  task automatic defer(input logic [7:0] id, input logic ood);
    @(posedge clk_in);
    id_n_out <= ~id;
    ids_n_out <= 1'h0;
    ood_n_out <= ~ood;
    @(posedge clk_in);
    id_n_out <= id;
    ids_n_out <= 1'h1;
    ood_n_out <= ood;
  endtask
  task automatic take_bus(output int waited);
    waited = 0;
    @(posedge clk_in);
    prio_n_out <= 1'h0;
    do begin
      @(posedge clk_in);
      waited++;
    end while (!atomic_n_in && waited < 64);
    @(posedge clk_in);
    prio_n_out <= 1'h1;
  endtask
endmodule

// File: bench/test_fsc_top.sv
// Directed bench for the sideband control block.
module test_fsc_top
  import fsc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk_in = 1'h0;
  logic rst_n_in = 1'h0;
  logic [7:0] reg_addr_in = 8'h00;
  logic [31:0] reg_wdata_in = 32'h0;
  logic reg_wr_in = 1'h0, reg_rd_in = 1'h0, ood_data_valid_in = 1'h0, error_detect_in = 1'h0;
  logic fp_error_in = 1'h0, fp_instr_in = 1'h0, snoop_req_in = 1'h0, lock_begin_in = 1'h0, lock_end_in = 1'h0;
  logic ignore_numeric_error_n_in = 1'h1, soft_init_n_in = 1'h1;
  logic [1:0] local_interrupt_pins_in = 2'h0;
  logic [7:0] transaction_id_n_in, deferred_id_out;
  logic [31:0] reg_rdata_out, resume_vector_out, v;
  logic [1:0] local_interrupt_out;
  logic irq_out, id_strobe_n_in, out_of_order_data_n_in, priority_request_n_in, deferred_start_out;
  logic deferred_ood_out, ood_data_accept_out, internal_error_n_out, shutdown_req_out, fp_exception_out;
  logic integer_reset_out, resume_out, bist_start_out, snoop_ack_out, maskable_interrupt_request_out, nmi_out;
  logic atomic_sequence_n_out, atomic_sequence_oe_n_out;
  logic [7:0] ra[5] = '{REG_CTRL, REG_VECTOR, REG_STATUS, REG_MASK, 8'h14};
  logic [31:0] rv[5] = '{{30'h0, CTRL_RESET}, VECTOR_RESET, 32'h0, 32'h0, 32'h0};
  int failures = 0;
  int num_checks = 0;
  int w;

  fsc_top u_fsc_top (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
    .irq_out(irq_out), .transaction_id_n_in(transaction_id_n_in), .id_strobe_n_in(id_strobe_n_in),
    .out_of_order_data_n_in(out_of_order_data_n_in), .deferred_start_out(deferred_start_out),
    .deferred_id_out(deferred_id_out), .deferred_ood_out(deferred_ood_out), .ood_data_valid_in(ood_data_valid_in),
    .ood_data_accept_out(ood_data_accept_out), .error_detect_in(error_detect_in),
    .internal_error_n_out(internal_error_n_out), .shutdown_req_out(shutdown_req_out),
    .ignore_numeric_error_n_in(ignore_numeric_error_n_in), .fp_error_in(fp_error_in), .fp_instr_in(fp_instr_in),
    .fp_exception_out(fp_exception_out), .soft_init_n_in(soft_init_n_in), .integer_reset_out(integer_reset_out),
    .resume_out(resume_out), .resume_vector_out(resume_vector_out), .bist_start_out(bist_start_out),
    .snoop_req_in(snoop_req_in), .snoop_ack_out(snoop_ack_out), .local_interrupt_pins_in(local_interrupt_pins_in),
    .local_interrupt_out(local_interrupt_out), .maskable_interrupt_request_out(maskable_interrupt_request_out),
    .nmi_out(nmi_out), .lock_begin_in(lock_begin_in), .lock_end_in(lock_end_in),
    .priority_request_n_in(priority_request_n_in), .atomic_sequence_n_out(atomic_sequence_n_out),
    .atomic_sequence_oe_n_out(atomic_sequence_oe_n_out));
  fsc_agent_model u_fsc_agent_model (.clk_in(sys_clk_in), .atomic_n_in(atomic_sequence_n_out),
    .id_n_out(transaction_id_n_in), .ids_n_out(id_strobe_n_in), .ood_n_out(out_of_order_data_n_in),
    .prio_n_out(priority_request_n_in));

  initial begin
    forever #2 sys_clk_in = ~sys_clk_in;
  end

  // ==========================================================
  // Shared tasks
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", n, e, g);
    end
  endtask
  task summarize();
    $display("checks %0d, failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task settle(input int n);
    repeat (n) @(posedge sys_clk_in);
    #1;
  endtask
  task automatic await(input string n, ref logic s);
    // Stepping off the edge first keeps a pulse launched on this edge from being read early.
    #1;
    for (int i = 0; i < 50 && s !== 1'h1; i++) begin
      settle(1);
    end
    chk(n, 32'h1, {31'h0, s});
    if (s !== 1'h1) begin
      summarize();
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_in);
    reg_wr_in <= 1'h1;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge sys_clk_in);
    reg_wr_in <= 1'h0;
  endtask
  task rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk_in);
    reg_rd_in <= 1'h1;
    reg_addr_in <= a;
    @(posedge sys_clk_in);
    reg_rd_in <= 1'h0;
    #1;
    d = reg_rdata_out;
  endtask
  task fp_try(input logic e);
    @(posedge sys_clk_in) fp_instr_in <= 1'h1;
    @(posedge sys_clk_in) fp_instr_in <= 1'h0;
    #1;
    chk("fp exception", {31'h0, e}, {31'h0, fp_exception_out});
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    repeat (10) @(posedge sys_clk_in);
    rst_n_in <= 1'h1;
    settle(4);
    foreach (ra[i]) begin
      rd(ra[i], v);
      chk("reset value", rv[i], v);
    end
    chk("error idle", 32'h1, internal_error_n_out);
    $display("test reset values finished");
    @(posedge sys_clk_in) local_interrupt_pins_in <= 2'h1;
    settle(5);
    chk("local pins", 32'h1, local_interrupt_out);
    chk("maskable_interrupt_request idle", 32'h0, maskable_interrupt_request_out);
    wr(REG_CTRL, 32'h0);
    @(posedge sys_clk_in) local_interrupt_pins_in <= 2'h3;
    await("nmi", nmi_out);
    settle(2);
    chk("maskable_interrupt_request", 32'h1, maskable_interrupt_request_out);
    chk("local pins off", 32'h0, local_interrupt_out);
    chk("irq masked", 32'h0, irq_out);
    wr(REG_MASK, 32'h10);
    settle(2);
    chk("irq", 32'h1, irq_out);
    wr(REG_STATUS, 32'h10);
    settle(2);
    chk("irq cleared", 32'h0, irq_out);
    @(posedge sys_clk_in) local_interrupt_pins_in <= 2'h0;
    $display("test interrupt pins finished");
    u_fsc_agent_model.defer(8'h5a, 1'h1);
    await("deferred start", deferred_start_out);
    chk("deferred id", 32'h5a, deferred_id_out);
    chk("deferred ood", 32'h1, deferred_ood_out);
    repeat (2) begin
      @(posedge sys_clk_in) ood_data_valid_in <= 1'h1;
      @(posedge sys_clk_in) ood_data_valid_in <= 1'h0;
      #1;
      chk("ood accept", {31'h0, w == 0}, ood_data_accept_out);
      w = 1;
    end
    u_fsc_agent_model.defer(8'ha5, 1'h0);
    u_fsc_agent_model.defer(8'h3c, 1'h0);
    settle(3);
    chk("second id", 32'h3c, deferred_id_out);
    rd(REG_STATUS, v);
    chk("defer status", 32'h1, v[ST_DEFER]);
    $display("test deferred phase finished");
    @(posedge sys_clk_in) fp_error_in <= 1'h1;
    @(posedge sys_clk_in) fp_error_in <= 1'h0;
    fp_try(1'h1);
    @(posedge sys_clk_in) fp_error_in <= 1'h1;
    ignore_numeric_error_n_in <= 1'h0;
    @(posedge sys_clk_in) fp_error_in <= 1'h0;
    settle(8);
    fp_try(1'h0);
    wr(REG_CTRL, 32'h1);
    fp_try(1'h1);
    @(posedge sys_clk_in) ignore_numeric_error_n_in <= 1'h1;
    $display("test numeric error finished");
    @(posedge sys_clk_in) error_detect_in <= 1'h1;
    @(posedge sys_clk_in) error_detect_in <= 1'h0;
    #1;
    chk("error flag", 32'h0, internal_error_n_out);
    chk("shutdown", 32'h1, shutdown_req_out);
    settle(20);
    chk("error held", 32'h0, internal_error_n_out);
    $display("test internal error finished");
    @(posedge sys_clk_in) lock_begin_in <= 1'h1;
    @(posedge sys_clk_in) lock_begin_in <= 1'h0;
    #1;
    chk("lock", 32'h0, atomic_sequence_n_out);
    fork
      u_fsc_agent_model.take_bus(w);
      begin
        settle(6);
        @(posedge sys_clk_in) lock_end_in <= 1'h1;
        @(posedge sys_clk_in) lock_end_in <= 1'h0;
      end
    join
    chk("bus wait", 32'h1, w > 6 && w < 64);
    rd(REG_STATUS, v);
    chk("prio status", 32'h1, v[ST_PRIO]);
    $display("test atomic lock finished");
    @(posedge sys_clk_in) soft_init_n_in <= 1'h0;
    rst_n_in <= 1'h0;
    #1;
    chk("error reset", 32'h1, internal_error_n_out);
    repeat (10) @(posedge sys_clk_in);
    rst_n_in <= 1'h1;
    await("self test", bist_start_out);
    @(posedge sys_clk_in) snoop_req_in <= 1'h1;
    await("integer reset", integer_reset_out);
    await("snoop ack", snoop_ack_out);
    wr(REG_VECTOR, 32'h1234_5678);
    rd(REG_STATUS, v);
    chk("bist status", 32'h1, v[ST_BIST]);
    @(posedge sys_clk_in) soft_init_n_in <= 1'h1;
    snoop_req_in <= 1'h0;
    await("resume", resume_out);
    chk("resume vector", 32'h1234_5678, resume_vector_out);
    @(posedge sys_clk_in) soft_init_n_in <= 1'h0;
    await("init again", integer_reset_out);
    rd(REG_STATUS, v);
    chk("init status", 32'h1, v[ST_INIT]);
    $display("test init and self test finished");
    summarize();
  end
endmodule
